/* src/redriver_pkg.sv */
// Operation
// (R01) Enable low holds standby with every redriver path off; high runs normally.
// (R02) Select one picks channel 1 output; select two picks channel 2 input.
// (R03) Low or open select activates side A; high select activates side B.
// (R04) Deemphasis code: 00 0dB low swing, 01 0dB, 10 3.5dB, 11 6dB.
// (R05) Deemphasis code 00 puts that output in low-swing mode.
// (R06) Equalization code: MSB low 0dB, 10 gives 3.5dB, 11 gives 6dB.
// (R07) Three outputs own deemphasis codes; three inputs own equalization codes.
// (R08) Detection starts on enable rising, including power-up with enable high.
// (R09) While enabled, any edge on trigger or either select restarts detection.
// (R10) During detection stay in standby with outputs squelched.
// (R11) Detection retries without limit until one channel is found; trigger level alone starts nothing.
// (R12) After one channel is found, at most 2^16 more attempts on other.
// (R13) Found channel gets its driver and idle squelch enabled.
// (R14) Enable low keeps detection inactive whatever the other pins do.
// (R15) Enabled output squelched while input idle, redriven while input active.
// (R16) Every control input reads low when left unconnected.
// (R17) Controller toggles trigger while enabled to repeat detection.
// (R18) Pin edges seen after synchronising; attempt spacing chosen by design.
package redriver_pkg;

   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] INTERVAL_OFFSET = 8'h04;
   localparam logic [7:0] STATUS_OFFSET = 8'h08;
   localparam logic [7:0] PINS_OFFSET = 8'h0c;
   localparam logic [7:0] ATTEMPTS_OFFSET = 8'h10;

   localparam int CTRL_RETRIGGER_BIT = 0;
   localparam int STATUS_ENABLE_BIT = 0;
   localparam int STATUS_DETECTING_BIT = 1;
   localparam int STATUS_FOUND_BIT = 2;
   localparam int STATUS_ABANDON_BIT = 4;
   localparam int STATUS_STANDBY_BIT = 6;

   localparam int CLK_PERIOD_NS = 8;
   localparam int PROBE_INTERVAL_NS = 8000;
   localparam logic [15:0] INTERVAL_RESET = 16'(PROBE_INTERVAL_NS / CLK_PERIOD_NS);
   localparam int ATTEMPT_LIMIT_DEFAULT = 65536;

   // Synchronised pin vector layout
   localparam int PIN_EN = 0;
   localparam int PIN_OUT_SEL = 1;
   localparam int PIN_IN_SEL = 2;
   localparam int PIN_TRIG = 3;
   localparam int PIN_RX = 4;
   localparam int PIN_IDLE = 6;
   localparam int PIN_DEEMPH = 8;
   localparam int PIN_EQ = 14;
   localparam int PIN_COUNT = 20;
   localparam int NUM_CODES = 3;

   typedef enum logic [1:0] {
      DET_OFF = 2'b00,
      DET_PROBE = 2'b01,
      DET_RUN = 2'b11
   } det_state_type;

   typedef enum logic [1:0] {
      LEVEL_0DB = 2'b00,
      LEVEL_3P5DB = 2'b01,
      LEVEL_6DB = 2'b10
   } level_type;

   function automatic level_type deemph_level(input logic [1:0] code);
      unique case (code) // R04
         2'b10: deemph_level = LEVEL_3P5DB;
         2'b11: deemph_level = LEVEL_6DB;
         default: deemph_level = LEVEL_0DB;
      endcase
   endfunction

   function automatic level_type eq_level(input logic [1:0] code);
      if (!code[1]) begin // R06
         eq_level = LEVEL_0DB;
      end else if (code[0]) begin
         eq_level = LEVEL_6DB;
      end else begin
         eq_level = LEVEL_3P5DB;
      end
   endfunction

endpackage

/* src/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [WIDTH-1:0] pins_in,
   output logic [WIDTH-1:0] pins_out
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] stage2_reg;
   logic [WIDTH-1:0] stage3_reg;
   logic [WIDTH-1:0] out_reg;
   logic [WIDTH-1:0] out_next;

   // Accept a change only once two settled stages agree
   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         out_next[i] = (stage2_reg[i] == stage3_reg[i]) ? stage3_reg[i] : out_reg[i]; // R18
      end
   end

   // Reset to low so an open pin reads low
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_reg <= '0;
         stage2_reg <= '0;
         stage3_reg <= '0;
         out_reg <= '0; // R16
      end else begin
         meta_reg <= pins_in;
         stage2_reg <= meta_reg;
         stage3_reg <= stage2_reg;
         out_reg <= out_next;
      end
   end

   assign pins_out = out_reg;
endmodule

/* src/redriver_mux_control.sv */
// The address map and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module redriver_mux_control
   import redriver_pkg::*;
#(
   parameter int ATTEMPT_LIMIT = ATTEMPT_LIMIT_DEFAULT
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic enable,
   input wire logic ch1_output_path_select,
   input wire logic ch2_input_path_select,
   input wire logic receiver_probe_trigger,
   input wire logic ch1_out_a_deemph_lsb,
   input wire logic ch1_out_a_deemph_msb,
   input wire logic ch1_out_b_deemph_lsb,
   input wire logic ch1_out_b_deemph_msb,
   input wire logic ch2_out_deemph_lsb,
   input wire logic ch2_out_deemph_msb,
   input wire logic ch1_in_eq_lsb,
   input wire logic ch1_in_eq_msb,
   input wire logic ch2_in_a_eq_lsb,
   input wire logic ch2_in_a_eq_msb,
   input wire logic ch2_in_b_eq_lsb,
   input wire logic ch2_in_b_eq_msb,
   input wire logic ch1_rx_present,
   input wire logic ch2_rx_present,
   input wire logic ch1_in_idle,
   input wire logic ch2_in_idle,
   output logic standby,
   output logic ch1_probe,
   output logic ch2_probe,
   output logic ch1_out_a_drive,
   output logic ch1_out_b_drive,
   output logic ch2_in_a_active,
   output logic ch2_in_b_active,
   output logic ch2_out_drive,
   output logic ch1_squelch,
   output logic ch2_squelch,
   output logic ch1_out_a_low_swing,
   output logic ch1_out_b_low_swing,
   output logic ch2_out_low_swing,
   output logic [1:0] ch1_out_a_deemph_level,
   output logic [1:0] ch1_out_b_deemph_level,
   output logic [1:0] ch2_out_deemph_level,
   output logic [1:0] ch1_in_eq_level,
   output logic [1:0] ch2_in_a_eq_level,
   output logic [1:0] ch2_in_b_eq_level
);
   logic [PIN_COUNT-1:0] pins_raw;
   logic [PIN_COUNT-1:0] pins;

   assign pins_raw = {ch2_in_b_eq_msb, ch2_in_b_eq_lsb, ch2_in_a_eq_msb, ch2_in_a_eq_lsb,
                      ch1_in_eq_msb, ch1_in_eq_lsb,
                      ch2_out_deemph_msb, ch2_out_deemph_lsb,
                      ch1_out_b_deemph_msb, ch1_out_b_deemph_lsb,
                      ch1_out_a_deemph_msb, ch1_out_a_deemph_lsb,
                      ch2_in_idle, ch1_in_idle, ch2_rx_present, ch1_rx_present,
                      receiver_probe_trigger, ch2_input_path_select,
                      ch1_output_path_select, enable};

   pin_sync #(
      .WIDTH(PIN_COUNT)
   ) u_pin_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .pins_in(pins_raw),
      .pins_out(pins)
   );

   logic en;
   logic out_sel;
   logic in_sel;
   logic [1:0] rx_present;
   logic [1:0] in_idle;

   assign en = pins[PIN_EN];
   assign out_sel = pins[PIN_OUT_SEL];
   assign in_sel = pins[PIN_IN_SEL];
   assign rx_present = pins[PIN_RX+1:PIN_RX];
   assign in_idle = pins[PIN_IDLE+1:PIN_IDLE];

   // Bus slave: zero wait states, always OKAY
   logic wr_pend_reg;
   logic wr_pend_next;
   logic [7:0] wr_addr_reg;
   logic [7:0] wr_addr_next;
   logic [31:0] hrdata_reg;
   logic [31:0] hrdata_next;
   logic [15:0] interval_reg;
   logic [15:0] interval_next;
   logic sw_trig_reg;
   logic sw_trig_next;
   logic addr_phase;
   logic [31:0] status_word;

   det_state_type state_reg;
   det_state_type state_next;
   logic [1:0] found_reg;
   logic [1:0] found_next;
   logic [1:0] abandon_reg;
   logic [1:0] abandon_next;
   logic [16:0] attempts_reg;
   logic [16:0] attempts_next;
   logic [15:0] tick_reg;
   logic [15:0] tick_next;
   logic [1:0] probe_reg;
   logic [1:0] probe_next;
   logic [3:0] prev_reg;
   logic [3:0] prev_next;

   assign addr_phase = hsel && htrans[1] && hready;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_reg;

   always_comb begin
      status_word = '0;
      status_word[STATUS_ENABLE_BIT] = en;
      status_word[STATUS_DETECTING_BIT] = (state_reg == DET_PROBE);
      status_word[STATUS_FOUND_BIT+1:STATUS_FOUND_BIT] = found_reg;
      status_word[STATUS_ABANDON_BIT+1:STATUS_ABANDON_BIT] = abandon_reg;
      status_word[STATUS_STANDBY_BIT] = (state_reg != DET_RUN);
   end

   always_comb begin
      wr_pend_next = addr_phase && hwrite;
      wr_addr_next = addr_phase ? haddr[7:0] : wr_addr_reg;
      interval_next = interval_reg;
      sw_trig_next = 1'b0;
      hrdata_next = '0;
      if (wr_pend_reg) begin
         unique case (wr_addr_reg)
            CTRL_OFFSET: sw_trig_next = hwdata[CTRL_RETRIGGER_BIT];
            // Zero is kept at one, though with the tick check both values give a probe every cycle
            INTERVAL_OFFSET: interval_next = (hwdata[15:0] == '0) ? 16'h0001 : hwdata[15:0];
            default: interval_next = interval_reg;
         endcase
      end
      if (addr_phase && !hwrite) begin
         unique case (haddr[7:0])
            INTERVAL_OFFSET: hrdata_next = {16'h0000, interval_reg};
            STATUS_OFFSET: hrdata_next = status_word;
            PINS_OFFSET: hrdata_next = {{(32-PIN_COUNT){1'b0}}, pins};
            ATTEMPTS_OFFSET: hrdata_next = {15'h0000, attempts_reg};
            default: hrdata_next = '0;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         hrdata_reg <= 32'h0000_0000;
         interval_reg <= INTERVAL_RESET;
         sw_trig_reg <= 1'b0;
      end else begin
         wr_pend_reg <= wr_pend_next;
         wr_addr_reg <= wr_addr_next;
         hrdata_reg <= hrdata_next;
         interval_reg <= interval_next;
         sw_trig_reg <= sw_trig_next;
      end
   end

   // Detection sequencer
   logic en_rise;
   logic pin_edge;
   logic [1:0] resolved;

   // Previous enable starts low, so enable high at power-up counts as a rise
   assign en_rise = en && !prev_reg[0]; // R08
   assign pin_edge = (pins[PIN_TRIG:PIN_OUT_SEL] != prev_reg[3:1]); // R09 R11
   assign resolved = found_reg | abandon_reg;

   always_comb begin
      state_next = state_reg;
      found_next = found_reg;
      abandon_next = abandon_reg;
      attempts_next = attempts_reg;
      tick_next = tick_reg;
      probe_next = 2'b00;
      prev_next = {pins[PIN_TRIG:PIN_OUT_SEL], en};
      if (!en) begin
         state_next = DET_OFF; // R01 R14
         found_next = 2'b00;
         abandon_next = 2'b00;
         attempts_next = '0;
      end else if (en_rise || pin_edge || sw_trig_reg) begin
         state_next = DET_PROBE; // R08 R09 R10
         found_next = 2'b00;
         abandon_next = 2'b00;
         attempts_next = '0;
         tick_next = interval_reg;
      end else begin
         unique case (state_reg)
            DET_PROBE: begin
               if (resolved == 2'b11) begin
                  state_next = DET_RUN; // R13
               end else if (tick_reg <= 16'h0001) begin
                  tick_next = interval_reg; // R18
                  for (int i = 0; i < 2; i++) begin
                     if (!resolved[i]) begin
                        if (rx_present[i]) begin
                           found_next[i] = 1'b1;
                        end else if (found_reg[1-i] && attempts_reg == 17'(ATTEMPT_LIMIT)) begin
                           abandon_next[i] = 1'b1; // R12
                        end else begin
                           probe_next[i] = 1'b1; // R11
                           if (found_reg[1-i]) begin
                              attempts_next = attempts_reg + 17'h00001; // R12
                           end
                        end
                     end
                  end
               end else begin
                  tick_next = tick_reg - 16'h0001;
               end
            end
            DET_RUN: state_next = DET_RUN;
            default: state_next = DET_OFF;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= DET_OFF;
         found_reg <= 2'b00;
         abandon_reg <= 2'b00;
         attempts_reg <= 17'h00000;
         tick_reg <= 16'h0000;
         probe_reg <= 2'b00;
         prev_reg <= 4'h0;
      end else begin
         state_reg <= state_next;
         found_reg <= found_next;
         abandon_reg <= abandon_next;
         attempts_reg <= attempts_next;
         tick_reg <= tick_next;
         probe_reg <= probe_next;
         prev_reg <= prev_next;
      end
   end

   assign ch1_probe = probe_reg[0];
   assign ch2_probe = probe_reg[1];

   // Path enables and squelch, registered
   logic [7:0] path_reg;
   logic [7:0] path_next;
   logic run;

   assign run = (state_reg == DET_RUN);

   always_comb begin
      path_next[0] = !run; // R01 R10
      path_next[1] = run && found_reg[0] && !out_sel; // R02 R03 R13
      path_next[2] = run && found_reg[0] && out_sel; // R02 R03 R13
      path_next[3] = run && found_reg[1] && !in_sel; // R02 R03
      path_next[4] = run && found_reg[1] && in_sel; // R02 R03
      path_next[5] = run && found_reg[1]; // R13
      // Idle squelch only acts once the channel has been found
      path_next[6] = !(run && found_reg[0]) || in_idle[0]; // R15
      path_next[7] = !(run && found_reg[1]) || in_idle[1]; // R15
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         path_reg <= 8'hc1;
      end else begin
         path_reg <= path_next;
      end
   end

   assign standby = path_reg[0];
   assign ch1_out_a_drive = path_reg[1];
   assign ch1_out_b_drive = path_reg[2];
   assign ch2_in_a_active = path_reg[3];
   assign ch2_in_b_active = path_reg[4];
   assign ch2_out_drive = path_reg[5];
   assign ch1_squelch = path_reg[6];
   assign ch2_squelch = path_reg[7];

   // Code decoders, one per output and input
   logic [1:0] deemph_q [NUM_CODES];
   logic swing_q [NUM_CODES];
   logic [1:0] eq_q [NUM_CODES];

   genvar g;
   generate
      for (g = 0; g < NUM_CODES; g++) begin : gen_codes
         logic [1:0] deemph_next;
         logic swing_next;
         logic [1:0] eq_next;
         logic [1:0] deemph_reg;
         logic swing_reg;
         logic [1:0] eq_reg;

         always_comb begin
            deemph_next = deemph_level(pins[PIN_DEEMPH+2*g+1 -: 2]); // R04 R07
            swing_next = (pins[PIN_DEEMPH+2*g+1 -: 2] == 2'b00); // R05
            eq_next = eq_level(pins[PIN_EQ+2*g+1 -: 2]); // R06 R07
         end

         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               deemph_reg <= LEVEL_0DB;
               swing_reg <= 1'b1;
               eq_reg <= LEVEL_0DB;
            end else begin
               deemph_reg <= deemph_next;
               swing_reg <= swing_next;
               eq_reg <= eq_next;
            end
         end

         assign deemph_q[g] = deemph_reg;
         assign swing_q[g] = swing_reg;
         assign eq_q[g] = eq_reg;
      end
   endgenerate

   assign ch1_out_a_deemph_level = deemph_q[0];
   assign ch1_out_b_deemph_level = deemph_q[1];
   assign ch2_out_deemph_level = deemph_q[2];
   assign ch1_out_a_low_swing = swing_q[0];
   assign ch1_out_b_low_swing = swing_q[1];
   assign ch2_out_low_swing = swing_q[2];
   assign ch1_in_eq_level = eq_q[0];
   assign ch2_in_a_eq_level = eq_q[1];
   assign ch2_in_b_eq_level = eq_q[2];

endmodule

/* verification/far_end_model.sv */
`timescale 1ns/1ps
module far_end_model (
   input wire logic hclk,
   input wire logic attach,
   input wire logic [3:0] need,
   input wire logic probe,
   output logic rx_present
);
   logic [3:0] seen_reg;
   // Receiver answers only after need probes; detached reads as absent
   always_ff @(posedge hclk) begin
      if (!attach) begin
         seen_reg <= 4'h0;
      end else if (probe && seen_reg != 4'hf) begin
         seen_reg <= seen_reg + 4'h1;
      end
   end
   assign rx_present = attach && (seen_reg >= need);
endmodule

/* verification/redriver_monitor.sv */
`timescale 1ns/1ps
module redriver_monitor (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic enable,
   input wire logic ch1_out_a_deemph_lsb,
   input wire logic ch1_out_a_deemph_msb,
   input wire logic ch1_out_a_low_swing,
   input wire logic [1:0] ch1_out_a_deemph_level,
   input wire logic ch2_out_deemph_lsb,
   input wire logic ch2_out_deemph_msb,
   input wire logic ch2_out_low_swing,
   input wire logic ch1_in_eq_msb,
   input wire logic [1:0] ch1_in_eq_level,
   input wire logic standby,
   input wire logic ch1_probe,
   input wire logic ch2_probe,
   input wire logic ch1_out_a_drive,
   input wire logic ch1_out_b_drive,
   input wire logic ch2_out_drive,
   input wire logic ch1_squelch,
   input wire logic ch1_in_idle
);
   default clocking @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // Eight steady cycles cover the synchroniser and the output register
   property p_low_swing;
      (!ch2_out_deemph_lsb && !ch2_out_deemph_msb)[*8] |-> ch2_out_low_swing;
   endproperty
   a_low_swing: assert property (p_low_swing) else $error("low swing missing");
   property p_deemph_6db;
      ({ch1_out_a_deemph_msb, ch1_out_a_deemph_lsb} == 2'b11)[*8]
         |-> ch1_out_a_deemph_level == 2'b10 && !ch1_out_a_low_swing;
   endproperty
   a_deemph_6db: assert property (p_deemph_6db) else $error("deemph code 11 wrong");
   property p_eq_zero;
      (!ch1_in_eq_msb)[*8] |-> ch1_in_eq_level == 2'b00;
   endproperty
   a_eq_zero: assert property (p_eq_zero) else $error("eq msb low not 0dB");
   property p_off;
      (!enable)[*8] |-> standby && !ch1_probe && !ch2_probe && !ch1_out_a_drive && !ch2_out_drive;
   endproperty
   a_off: assert property (p_off) else $error("active while disabled");
   property p_probe_quiet;
      ch1_probe || ch2_probe |-> standby && ch1_squelch && !ch2_out_drive;
   endproperty
   a_probe_quiet: assert property (p_probe_quiet) else $error("probe outside standby");
   property p_excl;
      !(ch1_out_a_drive && ch1_out_b_drive);
   endproperty
   a_excl: assert property (p_excl) else $error("both ch1 outputs driven");
   property p_drive_run;
      $rose(ch1_out_a_drive) || $rose(ch2_out_drive) |-> !standby;
   endproperty
   a_drive_run: assert property (p_drive_run) else $error("driver on in standby");
   property p_sq_active;
      ((ch1_out_a_drive || ch1_out_b_drive) && !ch1_in_idle)[*8] |-> !ch1_squelch;
   endproperty
   a_sq_active: assert property (p_sq_active) else $error("active input squelched");
   property p_sq_idle;
      ch1_in_idle[*8] |-> ch1_squelch;
   endproperty
   a_sq_idle: assert property (p_sq_idle) else $error("idle input redriven");
   c_probe: cover property (ch1_probe);
   c_run: cover property ($fell(standby));
   c_side_b: cover property (ch1_out_b_drive);
endmodule
bind redriver_mux_control redriver_monitor i_mon (.hclk, .hresetn, .enable,
   .ch1_out_a_deemph_lsb, .ch1_out_a_deemph_msb, .ch1_out_a_low_swing,
   .ch1_out_a_deemph_level, .ch2_out_deemph_lsb, .ch2_out_deemph_msb, .ch2_out_low_swing,
   .ch1_in_eq_msb, .ch1_in_eq_level, .standby, .ch1_probe, .ch2_probe, .ch1_out_a_drive,
   .ch1_out_b_drive, .ch2_out_drive, .ch1_squelch, .ch1_in_idle);

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import redriver_pkg::*;
   localparam int LIMIT = 4;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'b010;
   logic enable = 1'b0, out_sel = 1'b0, in_sel = 1'b0, trig = 1'b0;
   logic [1:0] dc [3] = '{2'b00, 2'b00, 2'b00};
   logic [1:0] ec [3] = '{2'b00, 2'b00, 2'b00};
   logic [1:0] attach = 2'b00, idle = 2'b00;
   logic [3:0] need [2] = '{4'h2, 4'h1};
   wire [1:0] rx, probe, sq;
   wire [2:0] de_seen [3];
   wire [1:0] eq_seen [3];
   wire [31:0] hrdata;
   wire hreadyout, hresp, standby, a_drv, b_drv, c2a, c2b, c2drv;
   wire [4:0] paths = {a_drv, b_drv, c2a, c2b, c2drv};
   int n_fail = 0, compares = 0, n_p1 = 0;
   always #4 hclk = ~hclk;
   always @(posedge hclk) if (probe[0]) n_p1 <= n_p1 + 1;
   for (genvar g = 0; g < 2; g++) begin : g_far
      far_end_model i_far (.hclk(hclk), .attach(attach[g]), .need(need[g]), .probe(probe[g]),
         .rx_present(rx[g]));
   end
   redriver_mux_control #(.ATTEMPT_LIMIT(LIMIT)) i_dut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .enable(enable), .ch1_output_path_select(out_sel),
      .ch2_input_path_select(in_sel), .receiver_probe_trigger(trig),
      .ch1_out_a_deemph_lsb(dc[0][0]), .ch1_out_a_deemph_msb(dc[0][1]),
      .ch1_out_b_deemph_lsb(dc[1][0]), .ch1_out_b_deemph_msb(dc[1][1]),
      .ch2_out_deemph_lsb(dc[2][0]), .ch2_out_deemph_msb(dc[2][1]),
      .ch1_in_eq_lsb(ec[0][0]), .ch1_in_eq_msb(ec[0][1]), .ch2_in_a_eq_lsb(ec[1][0]),
      .ch2_in_a_eq_msb(ec[1][1]), .ch2_in_b_eq_lsb(ec[2][0]), .ch2_in_b_eq_msb(ec[2][1]),
      .ch1_rx_present(rx[0]), .ch2_rx_present(rx[1]), .ch1_in_idle(idle[0]),
      .ch2_in_idle(idle[1]), .standby(standby), .ch1_probe(probe[0]), .ch2_probe(probe[1]),
      .ch1_out_a_drive(a_drv), .ch1_out_b_drive(b_drv), .ch2_in_a_active(c2a),
      .ch2_in_b_active(c2b), .ch2_out_drive(c2drv), .ch1_squelch(sq[0]), .ch2_squelch(sq[1]),
      .ch1_out_a_low_swing(de_seen[0][2]), .ch1_out_b_low_swing(de_seen[1][2]),
      .ch2_out_low_swing(de_seen[2][2]), .ch1_out_a_deemph_level(de_seen[0][1:0]),
      .ch1_out_b_deemph_level(de_seen[1][1:0]), .ch2_out_deemph_level(de_seen[2][1:0]),
      .ch1_in_eq_level(eq_seen[0]), .ch2_in_a_eq_level(eq_seen[1]),
      .ch2_in_b_eq_level(eq_seen[2]));

   task automatic tally_and_finish();
      $display("compares %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic hready_wait();
      int i;
      i = 0;
      do begin
         @(posedge hclk);
         i++;
      end while (hreadyout !== 1'b1 && i < 50);
      if (i >= 50) begin
         chk("hready_timeout", 1, 0);
         tally_and_finish();
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= w;
      hready_wait();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      hready_wait();
      rd = hrdata;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      bus(1'b0, a, 32'h0, rd);
      chk("register read", exp, rd);
      chk("hresp", 0, 32'(hresp));
   endtask
   // Bounded so a stuck detection ends the run instead of hanging it
   task automatic wait_sb(input logic v);
      int i;
      for (i = 0; i < 3000 && standby !== v; i++) @(posedge hclk);
      if (i >= 3000) begin
         chk("standby_timeout", 1, 0);
         tally_and_finish();
      end
   endtask
   function automatic logic [2:0] exp_de(input logic [1:0] c);
      case (c)
         2'b00: exp_de = 3'b100;
         2'b01: exp_de = 3'b000;
         2'b10: exp_de = 3'b001;
         default: exp_de = 3'b010;
      endcase
   endfunction
   function automatic logic [1:0] exp_eq(input logic [1:0] c);
      case (c)
         2'b10: exp_eq = 2'b01;
         2'b11: exp_eq = 2'b10;
         default: exp_eq = 2'b00;
      endcase
   endfunction

   initial begin
      logic [31:0] rd;
      int base;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk("standby", 1, standby);
      rd_chk(INTERVAL_OFFSET, 32'(INTERVAL_RESET));
      bus(1'b1, INTERVAL_OFFSET, 32'h0, rd);
      rd_chk(INTERVAL_OFFSET, 32'h1);
      bus(1'b1, INTERVAL_OFFSET, 32'h8, rd);
      rd_chk(INTERVAL_OFFSET, 32'h8);
      rd_chk(8'h40, 32'h0);
      for (int c = 0; c < 4; c++) begin
         for (int k = 0; k < 3; k++) begin
            dc[k] <= 2'(c + k);
            ec[k] <= 2'(c + 2 * k);
         end
         repeat (10) @(posedge hclk);
         for (int k = 0; k < 3; k++) begin
            chk("deemph", 32'(exp_de(2'(c + k))), 32'(de_seen[k]));
            chk("eq", 32'(exp_eq(2'(c + 2 * k))), 32'(eq_seen[k]));
         end
      end
      attach <= 2'b11;
      for (int i = 0; i < 4; i++) begin
         trig <= ~trig;
         out_sel <= ~out_sel;
         repeat (8) @(posedge hclk);
      end
      chk("disabled", 32'h20, {standby, paths});
      chk("no_probe", 0, n_p1);
      enable <= 1'b1;
      wait_sb(1'b0);
      chk("paths", 5'b10101, paths);
      rd_chk(STATUS_OFFSET, 32'h0d);
      idle <= 2'b01;
      repeat (10) @(posedge hclk);
      chk("squelch", 2'b01, sq);
      idle <= 2'b00;
      repeat (10) @(posedge hclk);
      chk("squelch", 2'b00, sq);
      out_sel <= 1'b1;
      in_sel <= 1'b1;
      wait_sb(1'b1);
      wait_sb(1'b0);
      chk("paths", 5'b01011, paths);
      trig <= ~trig;
      wait_sb(1'b1);
      wait_sb(1'b0);
      repeat (60) @(posedge hclk);
      chk("standby", 0, standby);
      attach <= 2'b01;
      need <= '{4'h0, 4'h0};
      trig <= ~trig;
      wait_sb(1'b1);
      wait_sb(1'b0);
      chk("abandon", 3'b010, {paths[4:3], paths[0]});
      rd_chk(ATTEMPTS_OFFSET, LIMIT);
      rd_chk(STATUS_OFFSET, 32'h25);
      attach <= 2'b00;
      bus(1'b1, CTRL_OFFSET, 32'h1, rd);
      wait_sb(1'b1);
      base = n_p1;
      repeat (200) @(posedge hclk);
      chk("retry", 1, 32'(n_p1 - base >= 10 && standby === 1'b1));
      chk("squelch", 2'b11, sq);
      enable <= 1'b0;
      repeat (10) @(posedge hclk);
      chk("off", 32'h20, {standby, paths});
      tally_and_finish();
   end
endmodule
